/* File: design/mcc_clock_gate.sv */
`timescale 1ns/1ns
// Runs or stops the high-speed source; crystal mode gates the oscillator enable,
// external mode gates the synchronised external clock level.
module mcc_clock_gate (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic hs_stop,
	input wire logic ext_mode,
	input wire logic ext_sync,
	output logic xtal_enable_r,
	output logic hs_clock_r
);
	// Enable follows the stop bit in crystal mode only
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			xtal_enable_r <= 1'b0;
		end else begin
			xtal_enable_r <= !hs_stop && !ext_mode;
		end
	end

	// External clock is passed only while enabled; stopped it reads low
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hs_clock_r <= 1'b0;
		end else begin
			hs_clock_r <= ext_mode && !hs_stop && ext_sync;
		end
	end
endmodule : mcc_clock_gate

/* File: design/mcc_main_clock_control.sv */
`timescale 1ns/1ns
// Clock-source control registers and clock-select decode
module mcc_main_clock_control #(
	parameter int STABLE_STEP = 16
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire mcc_pkg::mcc_bus_type bus,
	input wire logic ext_mode,
	input wire logic osc_pin_mode_select,
	input wire logic pll_select,
	input wire logic pulse_timer_clock_sel,
	input wire logic external_clock_input_pin,
	input wire logic crystal_input_pin,
	output logic [7:0] rdata_r,
	output logic hs_clock_stop_r,
	output logic main_clock_select_r,
	output logic xtal_enable_r,
	output logic hs_clock_r,
	output logic [4:0] periph_mult_r,
	output logic [4:0] periph_div_r,
	output logic [4:0] pulse_timer_clock_freq_r,
	output logic [4:0] pulse_timer_div_r
);
	initial begin
		if (STABLE_STEP < 1 || STABLE_STEP > 65535) $error("STABLE_STEP out of range");
	end

	logic [7:0] mode_r;
	logic [7:0] stable_sel_r;
	logic [mcc_pkg::STABLE_BITS-1:0] stable_r;
	logic [15:0] stable_cnt_r;
	logic ext_meta_r;
	logic ext_sync_r;
	logic xtal_meta_r;
	logic xtal_sync_r;
	logic wr_moc;
	logic wr_mcm;
	logic wr_oscillation_stable_time_select;
	logic [7:0] moc_nxt;
	logic [7:0] mcm_nxt;
	logic [7:0] moc_view;
	logic [7:0] mcm_view;

	assign wr_moc = bus.wr && bus.addr == mcc_pkg::ADDR_MAIN_OSC_CONTROL;
	assign wr_mcm = bus.wr && bus.addr == mcc_pkg::ADDR_MAIN_CLOCK_MODE;
	// Stable-time select takes byte writes only
	assign wr_oscillation_stable_time_select = bus.wr && !bus.bit_op && bus.addr == mcc_pkg::ADDR_OSC_STABLE_SELECT;

	// Register views; only the stop bit exists in the oscillator control byte
	always_comb begin
		moc_view = 8'h00;
		moc_view[mcc_pkg::BIT_HS_STOP] = hs_clock_stop_r;
		mcm_view = mode_r;
		mcm_view[mcc_pkg::BIT_CPU_STATUS] = main_clock_select_r;
	end

	// Bit writes modify one bit of the current view, byte writes replace it
	always_comb begin
		moc_nxt = moc_view;
		mcm_nxt = mode_r;
		if (bus.bit_op) begin
			moc_nxt[bus.bit_pos] = bus.bit_val;
			mcm_nxt[bus.bit_pos] = bus.bit_val;
		end else begin
			moc_nxt = bus.wdata;
			mcm_nxt = bus.wdata;
		end
	end

	// Stop bit; software must only set it while off the high-speed clock
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			hs_clock_stop_r <= mcc_pkg::RST_MAIN_OSC_CONTROL[mcc_pkg::BIT_HS_STOP];
		end else if (wr_moc) begin
			hs_clock_stop_r <= moc_nxt[mcc_pkg::BIT_HS_STOP];
		end
	end

	// Clock mode register; status bit is not writable
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			mode_r <= mcc_pkg::RST_MAIN_CLOCK_MODE;
		end else if (wr_mcm) begin
			mode_r <= mcm_nxt & mcc_pkg::MASK_MAIN_CLOCK_MODE_W;
		end
	end

	// Processor clock status follows the select (both select bits set) while the stop bit is clear, without waiting for stabilisation
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			main_clock_select_r <= 1'b0;
		end else begin
			main_clock_select_r <= mode_r[mcc_pkg::BIT_MAIN_SEL] && mode_r[mcc_pkg::BIT_XSEL]
				&& !hs_clock_stop_r;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stable_sel_r <= mcc_pkg::RST_OSC_STABLE_SELECT;
		end else if (wr_oscillation_stable_time_select) begin
			stable_sel_r <= bus.wdata & mcc_pkg::MASK_OSC_STABLE_SELECT;
		end
	end

	// Pin synchronisers; first stage feeds only the second
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			ext_meta_r <= 1'b0;
			ext_sync_r <= 1'b0;
			xtal_meta_r <= 1'b0;
			xtal_sync_r <= 1'b0;
		end else begin
			ext_meta_r <= external_clock_input_pin;
			ext_sync_r <= ext_meta_r;
			xtal_meta_r <= crystal_input_pin;
			xtal_sync_r <= xtal_meta_r;
		end
	end

	// Stabilisation count runs while the crystal runs, restarts when stopped
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stable_cnt_r <= 16'h0000;
			stable_r <= '0;
		end else if (hs_clock_stop_r || ext_mode || !osc_pin_mode_select) begin
			stable_cnt_r <= 16'h0000; // Pins as ports cannot oscillate
			stable_r <= '0;
		end else if (stable_cnt_r == 16'(STABLE_STEP - 1)) begin
			stable_cnt_r <= 16'h0000;
			stable_r <= {1'b1, stable_r[mcc_pkg::STABLE_BITS-1:1]};
		end else begin
			stable_cnt_r <= stable_cnt_r + 16'h0001;
		end
	end

	// Source clock ratio decode
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			periph_mult_r <= 5'h01;
			periph_div_r <= 5'h01;
			pulse_timer_clock_freq_r <= 5'h01;
			pulse_timer_div_r <= 5'h01;
		end else if (!pll_select) begin
			periph_mult_r <= 5'h01;
			periph_div_r <= 5'h01;
			pulse_timer_clock_freq_r <= 5'h01;
			pulse_timer_div_r <= 5'h01;
		end else begin
			periph_mult_r <= 5'(mcc_pkg::PLL_MULT);
			periph_div_r <= 5'(mcc_pkg::PERIPH_DIV);
			pulse_timer_clock_freq_r <= 5'(mcc_pkg::PLL_MULT);
			// Select one halves the timer clock as well
			pulse_timer_div_r <= pulse_timer_clock_sel ? 5'(mcc_pkg::PERIPH_DIV) : 5'h01;
		end
	end

	// Read data registered; unmapped addresses read zero
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rdata_r <= 8'h00;
		end else if (bus.rd) begin
			case (bus.addr)
				mcc_pkg::ADDR_MAIN_CLOCK_MODE: rdata_r <= mcm_view;
				mcc_pkg::ADDR_MAIN_OSC_CONTROL: rdata_r <= moc_view;
				mcc_pkg::ADDR_OSC_STABLE_STATUS: rdata_r <= {3'b000, stable_r};
				mcc_pkg::ADDR_OSC_STABLE_SELECT: rdata_r <= stable_sel_r;
				default: rdata_r <= 8'h00;
			endcase
		end
	end

	mcc_clock_gate u_gate (
		.clk(clk),
		.rst_n(rst_n),
		.hs_stop(hs_clock_stop_r),
		.ext_mode(ext_mode),
		.ext_sync(ext_sync_r),
		.xtal_enable_r(xtal_enable_r),
		.hs_clock_r(hs_clock_r)
	);
endmodule : mcc_main_clock_control

/* File: design/mcc_pkg.sv */
// How it works
// - Reset loads oscillator control with 80H
// - Stop bit clear runs crystal or accepts clock
// - Stop bit set halts crystal, ignores clock
// - Select zero: peripheral and timer equal main
// - Select one: ten times, peripheral halved
package mcc_pkg;
	localparam logic [15:0] ADDR_MAIN_CLOCK_MODE = 16'hffa1;
	localparam logic [15:0] ADDR_MAIN_OSC_CONTROL = 16'hffa2;
	localparam logic [15:0] ADDR_OSC_STABLE_STATUS = 16'hffa3;
	localparam logic [15:0] ADDR_OSC_STABLE_SELECT = 16'hffa4;
	localparam logic [7:0] RST_MAIN_CLOCK_MODE = 8'h00;
	localparam logic [7:0] RST_MAIN_OSC_CONTROL = 8'h80;
	localparam logic [7:0] RST_OSC_STABLE_SELECT = 8'h05;
	localparam int BIT_HS_STOP = 7;
	localparam int BIT_XSEL = 2;
	localparam int BIT_CPU_STATUS = 1;
	localparam int BIT_MAIN_SEL = 0;
	localparam logic [7:0] MASK_MAIN_CLOCK_MODE_W = 8'h05;
	localparam logic [7:0] MASK_OSC_STABLE_SELECT = 8'h07;
	localparam int PLL_MULT = 10;
	localparam int PERIPH_DIV = 2;
	// Stable-status bits fill from bit 4 down as the counter passes each step
	localparam int STABLE_BITS = 5;

	typedef struct packed {
		logic wr;
		logic rd;
		logic bit_op;
		logic [2:0] bit_pos;
		logic bit_val;
		logic [15:0] addr;
		logic [7:0] wdata;
	} mcc_bus_type;
endpackage : mcc_pkg

/* File: testbench/mcc_main_clock_control_properties.sv */
`timescale 1ns/1ns
module mcc_properties (
	input wire logic clk,
	input wire logic rst_n,
	input wire mcc_pkg::mcc_bus_type bus,
	input wire logic ext_mode,
	input wire logic pll_select,
	input wire logic pulse_timer_clock_sel,
	input wire logic [7:0] rdata_r,
	input wire logic hs_clock_stop_r,
	input wire logic xtal_enable_r,
	input wire logic hs_clock_r,
	input wire logic [4:0] periph_mult_r,
	input wire logic [4:0] periph_div_r,
	input wire logic [4:0] pulse_timer_clock_freq_r,
	input wire logic [4:0] pulse_timer_div_r
);
	localparam logic [15:0] MAIN_OSCILLATOR_CONTROL = mcc_pkg::ADDR_MAIN_OSC_CONTROL;
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// Byte writes to oscillator control land on the stop bit next cycle
	a_stop_byte_wr: assert property (bus.wr && !bus.bit_op && bus.addr == MAIN_OSCILLATOR_CONTROL |=>
		hs_clock_stop_r == $past(bus.wdata[7])) else $error("stop bit byte write lost");
	a_reset_stop: assert property ($rose(rst_n) |-> hs_clock_stop_r)
		else $error("stop bit not set after reset");
	a_xtal_run: assert property (!hs_clock_stop_r && !ext_mode |=> xtal_enable_r)
		else $error("crystal not running");
	a_xtal_halt: assert property (hs_clock_stop_r |=> !xtal_enable_r && !hs_clock_r)
		else $error("high-speed source not stopped");
	// Read data of oscillator control carries only the stop bit
	a_unused_zero: assert property (bus.rd && !bus.wr && bus.addr == MAIN_OSCILLATOR_CONTROL |=>
		rdata_r == {$past(hs_clock_stop_r), 7'h00}) else $error("oscillator control readback");
	a_pll_off: assert property (!pll_select |=> periph_mult_r == 5'h01 &&
		periph_div_r == 5'h01 && pulse_timer_clock_freq_r == 5'h01) else $error("ratio not 1");
	a_pll_periph: assert property (pll_select |=> periph_mult_r == 5'h0a &&
		periph_div_r == 5'h02) else $error("peripheral ratio wrong");
	a_pll_timer: assert property (pll_select && !pulse_timer_clock_sel |=>
		pulse_timer_clock_freq_r == 5'h0a && pulse_timer_div_r == 5'h01) else $error("timer ratio");
	c_xtal: cover property ($rose(xtal_enable_r));
	c_ext: cover property ($rose(hs_clock_r));
	c_pll: cover property (pll_select && pulse_timer_clock_sel);
endmodule : mcc_properties
bind mcc_main_clock_control mcc_properties i_mcc_properties (.*);

/* File: testbench/test_mcc_main_clock_control.sv */
`timescale 1ns/1ns
module test_mcc_main_clock_control;
	localparam logic [15:0] MAIN_OSCILLATOR_CONTROL = mcc_pkg::ADDR_MAIN_OSC_CONTROL;
	logic clk = 0, rst_n = 0, ext_mode = 0, osc_pin_mode_select = 1, pll_select = 0;
	logic pulse_timer_clock_sel = 0, external_clock_input_pin = 0, crystal_input_pin = 0;
	mcc_pkg::mcc_bus_type bus = '0;
	logic [7:0] rdata_r;
	logic hs_clock_stop_r, main_clock_select_r, xtal_enable_r, hs_clock_r;
	logic [4:0] periph_mult_r, periph_div_r, pulse_timer_clock_freq_r, pulse_timer_div_r;
	int error_cnt = 0, n_compared = 0, cyc = 0;
	mcc_main_clock_control #(.STABLE_STEP(2)) i_mcc_main_clock_control (.*);
	initial forever #10 clk = ~clk;
	// Watchdog: the whole run needs under a hundred cycles
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (cyc == 2000) begin
			error_cnt++;
			wrap_up();
		end
	end
	task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_compared++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED %s exp %h got %h", nm, e, g);
		end
	endtask : chk
	// One access, held from one falling edge to the next so one rising edge takes it
	task acc(input logic w, bo, bv, input logic [2:0] bp, input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		bus = '{wr: w, rd: !w, bit_op: bo, bit_pos: bp, bit_val: bv, addr: a, wdata: d};
		@(negedge clk);
		bus = '0;
	endtask : acc
	task rd_chk(input string nm, input logic [15:0] a, input logic [7:0] e);
		acc(0, 0, 0, 3'h0, a, 8'h00);
		chk(nm, e, rdata_r);
	endtask : rd_chk
	task t_reset;
		rd_chk("moc", MAIN_OSCILLATOR_CONTROL, 8'h80);
		rd_chk("mode", mcc_pkg::ADDR_MAIN_CLOCK_MODE, 8'h00);
		rd_chk("oscillation_stable_time_select", mcc_pkg::ADDR_OSC_STABLE_SELECT, 8'h05);
		chk("xtal", 8'h00, xtal_enable_r);
	endtask : t_reset
	// CPU is back on the internal clock before the stop bit is set, so stopping is allowed
	task t_crystal;
		acc(1, 0, 0, 3'h0, MAIN_OSCILLATOR_CONTROL, 8'h00);
		@(negedge clk);
		chk("xtal", 8'h01, xtal_enable_r);
		// Select the high-speed clock; status bit must follow once running
		acc(1, 0, 0, 3'h0, mcc_pkg::ADDR_MAIN_CLOCK_MODE, 8'h07);
		rd_chk("mode", mcc_pkg::ADDR_MAIN_CLOCK_MODE, 8'h07);
		chk("mcs", 8'h01, main_clock_select_r);
		// Stabilisation status fills all five bits while the crystal runs
		repeat (10) @(negedge clk);
		rd_chk("oscillation_stable_counter_status", mcc_pkg::ADDR_OSC_STABLE_STATUS, 8'h1f);
		// Back to the internal clock before stopping; status must read clear
		acc(1, 0, 0, 3'h0, mcc_pkg::ADDR_MAIN_CLOCK_MODE, 8'h00);
		rd_chk("mode", mcc_pkg::ADDR_MAIN_CLOCK_MODE, 8'h00);
		// No peripheral runs from the internal clock in this bench
		acc(1, 1, 1, 3'h7, MAIN_OSCILLATOR_CONTROL, 8'h00);
		@(negedge clk);
		chk("xtal", 8'h00, xtal_enable_r);
		rd_chk("moc", MAIN_OSCILLATOR_CONTROL, 8'h80);
		rd_chk("oscillation_stable_counter_status", mcc_pkg::ADDR_OSC_STABLE_STATUS, 8'h00);
	endtask : t_crystal
	task t_unused;
		acc(1, 0, 0, 3'h0, MAIN_OSCILLATOR_CONTROL, 8'h7f);
		rd_chk("moc", MAIN_OSCILLATOR_CONTROL, 8'h00);
		acc(1, 1, 1, 3'h3, MAIN_OSCILLATOR_CONTROL, 8'h00);
		rd_chk("moc", MAIN_OSCILLATOR_CONTROL, 8'h00);
		acc(1, 0, 0, 3'h0, MAIN_OSCILLATOR_CONTROL, 8'h80);
	endtask : t_unused
	// External clock mode is selected before the stop bit is cleared
	task t_ext;
		ext_mode = 1;
		crystal_input_pin = 1;
		acc(1, 0, 0, 3'h0, MAIN_OSCILLATOR_CONTROL, 8'h00);
		external_clock_input_pin = 1;
		repeat (4) @(negedge clk);
		chk("hs_clock", 8'h01, hs_clock_r);
		chk("xtal", 8'h00, xtal_enable_r);
		acc(1, 1, 1, 3'h7, MAIN_OSCILLATOR_CONTROL, 8'h00);
		@(negedge clk);
		chk("hs_clock", 8'h00, hs_clock_r);
		external_clock_input_pin = 0;
		ext_mode = 0;
	endtask : t_ext
	task t_pll;
		for (int i = 0; i < 4; i++) begin
			{pll_select, pulse_timer_clock_sel} = 2'(i);
			repeat (2) @(negedge clk);
			chk("pmul", pll_select ? 8'h0a : 8'h01, periph_mult_r);
			chk("pdiv", pll_select ? 8'h02 : 8'h01, periph_div_r);
			chk("tmul", pll_select ? 8'h0a : 8'h01, pulse_timer_clock_freq_r);
			chk("tdiv", (pll_select && pulse_timer_clock_sel) ? 8'h02 : 8'h01, pulse_timer_div_r);
		end
	endtask : t_pll
	task wrap_up;
		if (error_cnt == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask : wrap_up
	initial begin
		repeat (3) @(negedge clk);
		rst_n = 1;
		t_reset();
		t_crystal();
		t_unused();
		t_ext();
		t_pll();
		wrap_up();
	end
endmodule : test_mcc_main_clock_control
